// file: pkg/lcdt_consts.vh
// constants for the segment lcd frame timing core: register map, fields,
// drive levels, sleep mode codes, drive time settings and axi responses.
// assumes inclusion by bare name from rtl files; definitions only.
//
// Behaviour
// [RL1] prescaler: 12-bit ripple counter, then 1-8 divider
// [RL2] prescale select picks divide 16 up to 4096
// [RL3] fine divide select divides further by 1-8
// [RL4] frame and common timing run off divider output
// [RL5] memory bit one energizes segment, zero not
// [RL6] frame starts addressing common zero, group zero data
// [RL7] then common one with next five registers
// [RL8] continue until all duty commons are addressed
// [RL9] display memory latched before each new frame
// [RL10] off segments in phase, on segments opposite
// [RL11] half bias one middle level, third two
// [RL12] outputs inhibited until supply target reached
// [RL13] drive time field limits buffers, then tri-state
// [RL14] low power waveform: latch and flag every second frame
// [RL15] synchronous clock runs in idle and power-save
// [RL16] async clock with rc runs idle, adc, power-save
// [RL17] external clock enable takes pin clock, not crystal
// [RL18] software disables lcd before deep sleep, sync clock
// [RL19] blanking after frame end grounds all pins
// [RL20] software blanks before disabling the controller
// [RL21] port mask releases unused segment pins
// [RL22] unused common pins return to port function
// [RL23] frame start flag set at latch, write one clears
// [RL24] clock source select one takes timer oscillator pin; code takes xtal_osc_clk unless extck is set
// [RL25] low power waveform change waits for next frame
`ifndef LCDT_CONSTS_VH
`define LCDT_CONSTS_VH

// register byte addresses
`define LCDT_ADDR_CTRL      8'h00
`define LCDT_ADDR_FRAME     8'h04
`define LCDT_ADDR_MASK      8'h08
`define LCDT_ADDR_STAT      8'h0c
`define LCDT_ADDR_DM_BASE   8'h40
`define LCDT_ADDR_DM_LAST   8'h8c

// control register bits
`define LCDT_CTRL_EN        0
`define LCDT_CTRL_LPW       1
`define LCDT_CTRL_BLANK     2
`define LCDT_CTRL_FLAG      3
`define LCDT_CTRL_CSRC      4
`define LCDT_CTRL_EXTCK     5
`define LCDT_CTRL_DUTY      9:8
`define LCDT_CTRL_BIAS3     10
`define LCDT_CTRL_RC        11
`define LCDT_CTRL_WMASK     32'h00000f37

// frame register fields
`define LCDT_FR_PS          2:0
`define LCDT_FR_CD          6:4
`define LCDT_FR_DT          10:8
`define LCDT_FR_WMASK       32'h00000777
`define LCDT_MASK_WMASK     32'h01ffffff

// geometry
`define LCDT_NSEG           25
`define LCDT_NCOM           4
`define LCDT_NDM            20
`define LCDT_DM_PER_COM     5

// drive levels, in steps of the bias fraction of the supply
`define LCDT_LVL_GND        2'h0
`define LCDT_LVL_LO         2'h1
`define LCDT_LVL_HI         2'h2
`define LCDT_LVL_TOP        2'h3

// drive time: (select + 1) << shift source ticks, select 7 = whole step
`define LCDT_DT_SHIFT       4
`define LCDT_DT_FULL        3'h7
`define LCDT_DT_MAX         8'hff

// sleep modes seen on sys_sleep_mode
`define LCDT_SLP_ACTIVE     3'h0
`define LCDT_SLP_IDLE       3'h1
`define LCDT_SLP_ADCNR      3'h2
`define LCDT_SLP_PSAVE      3'h3

// axi responses
`define LCDT_RESP_OKAY      2'h0
`define LCDT_RESP_SLVERR    2'h2

`endif

// file: rtl/lcdt_frame_timing.v
// segment lcd frame timing core: prescaler, common scan, level coding,
// drive-time gating, blanking, port masking, axi4-lite register slave.
// assumes one clock aclk; pin inputs are asynchronous and synced here;
// levels are coded for an analog switch matrix outside this block.
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "lcdt_consts.vh"

module lcdt_frame_timing (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        timer_osc_pin,
	input  wire        xtal_osc_clk,
	input  wire        vlcd_target_reached,
	input  wire [2:0]  sys_sleep_mode,
	output reg  [7:0]  com_level,
	output reg  [3:0]  com_oe,
	output reg  [3:0]  com_port_sel,
	output reg  [49:0] seg_level,
	output reg  [24:0] seg_oe,
	output reg  [24:0] seg_port_sel
);

	// software state
	reg  [31:0] ctrl_r;
	reg  [31:0] frame_r;
	reg  [31:0] mask_r;
	reg  [7:0]  dm_r [0:`LCDT_NDM-1];
	reg         flag_r;

	// bus state
	reg         aw_have_r;
	reg         w_have_r;
	reg  [7:0]  aw_addr_r;
	reg  [31:0] w_data_r;
	reg  [3:0]  w_strb_r;

	// synchronisers: three flops, change taken once stages two and three agree
	reg  [2:0]  sync_pin_r;
	reg  [2:0]  sync_xtal_r;
	reg  [2:0]  sync_vlcd_r;
	reg         pin_lvl_r;
	reg         xtal_lvl_r;
	reg         vlcd_ok_r;

	// timing state
	reg  [11:0] ripple_r;
	reg  [2:0]  fine_r;
	reg  [2:0]  step_r;
	reg         first_r;
	reg         parity_r;
	reg         lp_act_r;
	reg         blank_act_r;
	reg  [7:0]  dt_cnt_r;
	reg  [99:0] lat_r;

	// software fields
	wire        en       = ctrl_r[`LCDT_CTRL_EN];
	wire        csrc     = ctrl_r[`LCDT_CTRL_CSRC];
	wire        extck    = ctrl_r[`LCDT_CTRL_EXTCK];
	wire [1:0]  duty     = ctrl_r[`LCDT_CTRL_DUTY];
	wire        bias3    = ctrl_r[`LCDT_CTRL_BIAS3];
	wire        sys_rc   = ctrl_r[`LCDT_CTRL_RC];
	wire [2:0]  ps_sel   = frame_r[`LCDT_FR_PS];
	wire [2:0]  cd_sel   = frame_r[`LCDT_FR_CD];
	wire [2:0]  dt_sel   = frame_r[`LCDT_FR_DT];

	// source tick: aclk itself, or a rising edge of the chosen pin clock
	wire        pin_sel  = extck ? pin_lvl_r : xtal_lvl_r; // RL17
	wire        pin_new  = extck ? sync_pin_r[1] : sync_xtal_r[1];
	wire        pin_agr  = extck ? (sync_pin_r[1] == sync_pin_r[2])
	                             : (sync_xtal_r[1] == sync_xtal_r[2]);
	wire        pin_rise = pin_agr & pin_new & ~pin_sel;
	wire        src_tick = csrc ? pin_rise : 1'b1; // RL24

	// sleep modes in which the controller keeps running
	reg         sleep_ok;
	always @* begin
		case (sys_sleep_mode)
			`LCDT_SLP_ACTIVE: sleep_ok = 1'b1;
			`LCDT_SLP_IDLE:   sleep_ok = 1'b1; // RL15
			`LCDT_SLP_PSAVE:  sleep_ok = 1'b1; // RL15
			`LCDT_SLP_ADCNR:  sleep_ok = csrc & sys_rc; // RL16
			default:          sleep_ok = 1'b0;
		endcase
	end
	wire        run = en & sleep_ok;

	// prescaler tap: all low bits of the ripple counter at one
	reg  [11:0] ps_mask;
	always @* begin
		case (ps_sel)
			3'h0:    ps_mask = 12'h00f;
			3'h1:    ps_mask = 12'h03f;
			3'h2:    ps_mask = 12'h07f;
			3'h3:    ps_mask = 12'h0ff;
			3'h4:    ps_mask = 12'h1ff;
			3'h5:    ps_mask = 12'h3ff;
			3'h6:    ps_mask = 12'h7ff;
			default: ps_mask = 12'hfff;
		endcase
	end
	wire        ps_tick  = src_tick & ((ripple_r & ps_mask) == ps_mask); // RL2
	wire        lcd_tick = ps_tick & (fine_r == cd_sel); // RL3 RL4

	// common scan: default waveform uses two steps per common
	wire        lp_nxt_frame = ctrl_r[`LCDT_CTRL_LPW];
	wire [2:0]  last_step = lp_act_r ? {1'b0, duty} : {duty, 1'b1}; // RL8
	wire        frame_end = lcd_tick & ((step_r == last_step) | first_r);
	wire        latch_now = frame_end & (~lp_act_r | parity_r | first_r); // RL14
	wire [1:0]  com_idx  = lp_act_r ? step_r[1:0] : step_r[2:1];
	wire        pol      = lp_act_r ? parity_r : step_r[0];

	// drive time window measured from each step start
	wire [7:0]  dt_limit = {4'h0, ({1'b0, dt_sel} + 4'h1)} << `LCDT_DT_SHIFT;
	wire        drive_on = (dt_sel == `LCDT_DT_FULL) | (dt_cnt_r < dt_limit);

	// per-common view of display memory: first four of its five bytes, 25 bits used
	wire [99:0] dm_view;
	genvar gc;
	generate
		for (gc = 0; gc < `LCDT_NCOM; gc = gc + 1) begin : g_com_view
			assign dm_view[gc*25 +: 25] = {dm_r[gc*`LCDT_DM_PER_COM+3][0],
			                               dm_r[gc*`LCDT_DM_PER_COM+2],
			                               dm_r[gc*`LCDT_DM_PER_COM+1],
			                               dm_r[gc*`LCDT_DM_PER_COM]};
		end
	endgenerate

	// data of the addressed common
	reg  [24:0] cur_seg;
	always @* begin
		case (com_idx)
			2'h0:    cur_seg = lat_r[24:0]; // RL6
			2'h1:    cur_seg = lat_r[49:25]; // RL7
			2'h2:    cur_seg = lat_r[74:50];
			default: cur_seg = lat_r[99:75];
		endcase
	end

	// level coding; outputs settle to ground when not running, and to port when en is clear
	wire        live      = run & vlcd_ok_r & ~first_r; // RL12
	wire [1:0]  lvl_on    = pol ? `LCDT_LVL_TOP : `LCDT_LVL_GND;
	wire [1:0]  lvl_off_s = bias3 ? (pol ? `LCDT_LVL_LO : `LCDT_LVL_HI)
	                              : (pol ? `LCDT_LVL_GND : `LCDT_LVL_TOP);
	wire [1:0]  lvl_com_a = pol ? `LCDT_LVL_GND : `LCDT_LVL_TOP;
	wire [1:0]  lvl_com_n = (bias3 & pol) ? `LCDT_LVL_HI : `LCDT_LVL_LO;
	wire [49:0] seg_lvl_nxt;
	wire [24:0] seg_oe_nxt;
	wire [24:0] seg_port_nxt;
	wire [7:0]  com_lvl_nxt;
	wire [3:0]  com_oe_nxt;
	wire [3:0]  com_port_nxt;

	genvar gs;
	generate
		for (gs = 0; gs < `LCDT_NSEG; gs = gs + 1) begin : g_seg
			// on segment opposite the addressed common, off in phase
			assign seg_lvl_nxt[gs*2 +: 2] =
				(~live | blank_act_r) ? `LCDT_LVL_GND :
				(cur_seg[gs] ? lvl_on : lvl_off_s); // RL5 RL10 RL11 RL19
			assign seg_oe_nxt[gs] = live & ~mask_r[gs] &
			                        (blank_act_r | drive_on); // RL13
			assign seg_port_nxt[gs] = ~en | mask_r[gs]; // RL21
		end
		for (gc = 0; gc < `LCDT_NCOM; gc = gc + 1) begin : g_com
			// unused commons fall back to port pins
			assign com_port_nxt[gc] = ~en | (gc > duty); // RL22
			assign com_lvl_nxt[gc*2 +: 2] =
				(~live | blank_act_r) ? `LCDT_LVL_GND :
				(com_idx == gc) ? lvl_com_a : lvl_com_n; // RL6 RL11 RL19
			assign com_oe_nxt[gc] = live & (gc <= duty) &
			                        (blank_act_r | drive_on); // RL13
		end
	endgenerate

	// byte-lane merge for a register write
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					merge[k*8 +: 8] = data[k*8 +: 8];
				end
			end
		end
	endfunction

	// write decode happens once both address and data are held
	wire        do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
	wire        wr_dm    = (aw_addr_r[7:2] >= `LCDT_ADDR_DM_BASE >> 2) &
	                       (aw_addr_r[7:2] <= `LCDT_ADDR_DM_LAST >> 2);
	wire [7:0]  wr_dm_off = (aw_addr_r - `LCDT_ADDR_DM_BASE) >> 2;
	wire        wr_ctrl  = aw_addr_r[7:2] == (`LCDT_ADDR_CTRL >> 2);
	wire        wr_frame = aw_addr_r[7:2] == (`LCDT_ADDR_FRAME >> 2);
	wire        wr_mask  = aw_addr_r[7:2] == (`LCDT_ADDR_MASK >> 2);
	wire        wr_ok    = wr_dm | wr_ctrl | wr_frame | wr_mask |
	                       (aw_addr_r[7:2] == (`LCDT_ADDR_STAT >> 2));
	wire        clr_flag = do_write & wr_ctrl & w_strb_r[0] &
	                       w_data_r[`LCDT_CTRL_FLAG];

	// read decode
	wire        rd_go    = s_axi_arvalid & s_axi_arready;
	wire [7:0]  rd_dm_off = (s_axi_araddr - `LCDT_ADDR_DM_BASE) >> 2;
	wire        rd_dm    = (s_axi_araddr[7:2] >= `LCDT_ADDR_DM_BASE >> 2) &
	                       (s_axi_araddr[7:2] <= `LCDT_ADDR_DM_LAST >> 2);
	reg  [31:0] rd_data;
	reg         rd_ok;
	always @* begin
		rd_ok = 1'b1;
		rd_data = 32'h00000000;
		if (rd_dm) begin
			rd_data = {24'h000000, dm_r[rd_dm_off[4:0]]};
		end else begin
			case (s_axi_araddr[7:2])
				`LCDT_ADDR_CTRL >> 2:
					rd_data = (ctrl_r & `LCDT_CTRL_WMASK) |
					          ({31'h00000000, flag_r} << `LCDT_CTRL_FLAG);
				`LCDT_ADDR_FRAME >> 2: rd_data = frame_r;
				`LCDT_ADDR_MASK >> 2:  rd_data = mask_r;
				`LCDT_ADDR_STAT >> 2:
					rd_data = {24'h000000, run, parity_r, com_idx,
					           first_r, lp_act_r, blank_act_r, vlcd_ok_r};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// axi4-lite slave handshakes; one write and one read in flight
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h00000000;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `LCDT_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `LCDT_RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_r <= 1'b0;
			end
			// ready drops the cycle after a take, so each is taken once
			s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready) &
			                 ~s_axi_bvalid;
			s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready) &
			                 ~s_axi_bvalid;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `LCDT_RESP_OKAY : `LCDT_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~rd_go & ~s_axi_rvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_ok ? `LCDT_RESP_OKAY : `LCDT_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// software registers; the flag bit is never stored through ctrl_r
	integer i;
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r  <= 32'h00000000;
			frame_r <= 32'h00000000;
			mask_r  <= 32'h00000000;
			for (i = 0; i < `LCDT_NDM; i = i + 1) begin
				dm_r[i] <= 8'h00;
			end
		end else if (do_write) begin
			if (wr_ctrl) begin
				ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) &
				          `LCDT_CTRL_WMASK;
			end
			if (wr_frame) begin
				frame_r <= merge(frame_r, w_data_r, w_strb_r) &
				           `LCDT_FR_WMASK;
			end
			if (wr_mask) begin
				mask_r <= merge(mask_r, w_data_r, w_strb_r) &
				          `LCDT_MASK_WMASK;
			end
			if (wr_dm & w_strb_r[0]) begin
				dm_r[wr_dm_off[4:0]] <= w_data_r[7:0];
			end
		end
	end

	// frame start flag: a set in the clearing cycle wins
	always @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 1'b0;
		end else if (latch_now & run) begin
			flag_r <= 1'b1; // RL23 RL14
		end else if (clr_flag) begin
			flag_r <= 1'b0; // RL23
		end
	end

	// pin synchronisers
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync_pin_r  <= 3'h0;
			sync_xtal_r <= 3'h0;
			sync_vlcd_r <= 3'h0;
			pin_lvl_r   <= 1'b0;
			xtal_lvl_r  <= 1'b0;
			vlcd_ok_r   <= 1'b0;
		end else begin
			sync_pin_r  <= {sync_pin_r[1:0], timer_osc_pin};
			sync_xtal_r <= {sync_xtal_r[1:0], xtal_osc_clk};
			sync_vlcd_r <= {sync_vlcd_r[1:0], vlcd_target_reached};
			if (sync_pin_r[1] == sync_pin_r[2]) begin
				pin_lvl_r <= sync_pin_r[1];
			end
			if (sync_xtal_r[1] == sync_xtal_r[2]) begin
				xtal_lvl_r <= sync_xtal_r[1];
			end
			if (sync_vlcd_r[1] == sync_vlcd_r[2]) begin
				vlcd_ok_r <= sync_vlcd_r[1]; // RL12
			end
		end
	end

	// prescaler, fine divider and common scan
	always @(posedge aclk) begin
		if (!aresetn || !run) begin
			ripple_r    <= 12'h000;
			fine_r      <= 3'h0;
			step_r      <= 3'h0;
			first_r     <= 1'b1;
			parity_r    <= 1'b0;
			lp_act_r    <= 1'b0;
			blank_act_r <= 1'b0;
			dt_cnt_r    <= 8'h00;
			lat_r       <= 100'h0;
		end else begin
			if (src_tick) begin
				ripple_r <= ripple_r + 12'h001; // RL1
				if (dt_cnt_r != `LCDT_DT_MAX) begin
					dt_cnt_r <= dt_cnt_r + 8'h01;
				end
			end
			if (ps_tick) begin
				fine_r <= (fine_r == cd_sel) ? 3'h0 : fine_r + 3'h1; // RL1
			end
			if (lcd_tick) begin
				dt_cnt_r <= 8'h00; // RL13
				step_r   <= frame_end ? 3'h0 : step_r + 3'h1; // RL8
			end
			if (frame_end) begin
				// frame boundary: blanking takes effect here, waveform only at a latching one
				first_r     <= 1'b0;
				blank_act_r <= ctrl_r[`LCDT_CTRL_BLANK]; // RL19
				if (latch_now) begin
					lat_r    <= dm_view; // RL9
					parity_r <= 1'b0;
					lp_act_r <= lp_nxt_frame; // RL25
				end else begin
					parity_r <= 1'b1; // RL14
				end
			end
		end
	end

	// pin drivers, all registered
	always @(posedge aclk) begin
		if (!aresetn) begin
			com_level    <= 8'h00;
			com_oe       <= 4'h0;
			com_port_sel <= 4'hf;
			seg_level    <= 50'h0;
			seg_oe       <= 25'h0;
			seg_port_sel <= 25'h1ffffff;
		end else begin
			com_level    <= com_lvl_nxt;
			com_oe       <= com_oe_nxt;
			com_port_sel <= com_port_nxt;
			seg_level    <= seg_lvl_nxt;
			seg_oe       <= seg_oe_nxt;
			seg_port_sel <= seg_port_nxt;
		end
	end

endmodule
`default_nettype wire

// file: bench/lcdt_ft_props.sv
// checker for the lcd frame timing core: bus handshakes, output
// inhibit and reset state. assumes one clock domain on aclk.
`timescale 1ns/10ps
`default_nettype none
module lcdt_ft_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        vlcd_target_reached,
	input wire logic [3:0]  com_oe,
	input wire logic [3:0]  com_port_sel,
	input wire logic [24:0] seg_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// responses stand until taken; a write response then drops
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("bresp dropped early");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("rdata dropped early");
	property p_bdone;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bdone: assert property (p_bdone) else $error("second write response");
	// both held one edge after the take, bvalid set at the next
	property p_bwr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##2 s_axi_bvalid;
	endproperty
	a_bwr: assert property (p_bwr) else $error("write response late");
	// no new write accepted while a write response is pending
	property p_wbusy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wbusy: assert property (p_wbusy) else $error("write taken while busy");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_slverr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr inside {[8'h10:8'h3f]}
			|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_slverr: assert property (p_slverr) else $error("hole read not refused");
	// supply below target keeps every pin undriven
	property p_inhibit;
		!vlcd_target_reached [*8] |-> com_oe == 4'h0 && seg_oe == 25'h0;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("driven early");
	property p_rst;
		disable iff (1'b0) !aresetn |=> com_oe == 4'h0 && com_port_sel == 4'hf;
	endproperty
	a_rst: assert property (p_rst) else $error("pins not ports in reset");
endmodule
bind lcdt_frame_timing lcdt_ft_props u_props (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .vlcd_target_reached, .com_oe,
	.com_port_sel, .seg_oe);
`default_nettype wire

// file: bench/lcdt_panel_model.sv
// passive segment panel: marks a segment lit when full supply
// stands across it. assumes level codes 0 and 3 are the rails.
`timescale 1ns/10ps
`default_nettype none
module lcdt_panel_model (
	input wire logic        aclk,
	input wire logic        clr,
	input wire logic [7:0]  com_level,
	input wire logic [3:0]  com_oe,
	input wire logic [49:0] seg_level,
	input wire logic [24:0] seg_oe,
	output logic     [99:0] lit
);
	// only rail against rail counts, half swings never light a cell
	always @(posedge aclk) begin
		for (int c = 0; c < 4; c++)
			for (int s = 0; s < 25; s++)
				if (clr)
					lit[c*25+s] <= 1'b0;
				else if (com_oe[c] && seg_oe[s] &&
					{com_level[2*c+:2], seg_level[2*s+:2]} inside {4'h3, 4'hc})
					lit[c*25+s] <= 1'b1;
	end
endmodule
`default_nettype wire

// file: bench/lcdt_frame_timing_tb.sv
// testbench for the lcd frame timing core: bus master, scenarios
// and verdict. assumes the core, its constants and the panel model.
`timescale 1ns/10ps
`default_nettype none
`include "lcdt_consts.vh"
module lcdt_frame_timing_tb;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, clr;
	logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        timer_osc_pin, xtal_osc_clk, vlcd_target_reached;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, com_level;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat, ctl;
	logic [3:0]  s_axi_wstrb, com_oe, com_port_sel;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [2:0]  sys_sleep_mode;
	logic [49:0] seg_level;
	logic [24:0] seg_oe, seg_port_sel;
	logic [99:0] lit;
	int          err_total, comparisons;
	lcdt_frame_timing uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_osc_pin,
		.xtal_osc_clk, .vlcd_target_reached, .sys_sleep_mode, .com_level,
		.com_oe, .com_port_sel, .seg_level, .seg_oe, .seg_port_sel);
	lcdt_panel_model pm (.aclk, .clr, .com_level, .com_oe, .seg_level,
		.seg_oe, .lit);
	// system clock, then the two slow sources kept off its edges
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		#1;
		fork
			forever #32 timer_osc_pin = ~timer_osc_pin;
			forever #64 xtal_osc_clk = ~xtal_osc_clk;
		join
	end
	task automatic tally_and_finish();
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic give_up();
		err_total++;
		tally_and_finish();
	endtask
	task automatic chk(input logic [99:0] got, input logic [99:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bready only after bvalid is seen, so the slave must hold it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw = 1, w = 1, b = 1;
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (b) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 0;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				b = 0;
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end else if (s_axi_bvalid)
				s_axi_bready <= 1'b1;
			if (++n > 100)
				give_up();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		bit ar = 1, b = 1;
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (b) begin
			@(posedge aclk);
			if (ar && s_axi_arready) begin
				ar = 0;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				b = 0;
				rdat = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end else if (s_axi_rvalid)
				s_axi_rready <= 1'b1;
			if (++n > 100)
				give_up();
		end
	endtask
	task automatic set_ctl(input logic [31:0] v);
		ctl = v;
		wr(`LCDT_ADDR_CTRL, v);
	endtask
	// clear the frame flag, then poll until it comes back
	task automatic wait_flag();
		int n = 0;
		wr(`LCDT_ADDR_CTRL, ctl | 32'h8);
		do begin
			rd(`LCDT_ADDR_CTRL);
			if (++n > 2000)
				give_up();
		end while (rdat[3] !== 1'b1);
	endtask
	task automatic lvl_wait(output int n);
		logic [7:0] v;
		n = 0;
		v = com_level;
		while (com_level === v && n < 5000) begin
			@(posedge aclk);
			n++;
		end
	endtask
	task automatic s_bus();
		wr(8'h20, 32'h1);
		chk(resp, `LCDT_RESP_SLVERR);
		rd(8'h20);
		chk({rdat, resp}, {32'h0, `LCDT_RESP_SLVERR});
		wr(`LCDT_ADDR_FRAME, 32'hffffffff);
		rd(`LCDT_ADDR_FRAME);
		chk({rdat, resp}, {`LCDT_FR_WMASK, `LCDT_RESP_OKAY});
	endtask
	// every segment bit against what the panel saw over whole frames
	task automatic s_lit(input logic [7:0] p, input logic lp);
		logic [99:0] e;
		logic [7:0] b [20];
		for (int k = 0; k < 20; k++) begin
			b[k] = p + 8'(k * 37);
			wr(8'h40 + 8'(4 * k), {24'h0, b[k]});
		end
		for (int c = 0; c < 4; c++)
			for (int s = 0; s < 25; s++)
				e[c*25+s] = b[5*c+s/8][s%8];
		set_ctl(lp ? 32'h703 : 32'h701);
		wait_flag();
		wait_flag();
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		wait_flag();
		wait_flag();
		chk(lit, e);
		rd(`LCDT_ADDR_STAT);
		chk(rdat[2], lp);
	endtask
	task automatic s_drive(input logic [2:0] dt);
		int n = 0;
		wr(`LCDT_ADDR_FRAME, {21'h0, dt, 8'h01});
		wait_flag();
		repeat (512) begin
			@(posedge aclk);
			if (com_oe[0] === 1'b1)
				n++;
		end
		chk(n, dt == 3'h7 ? 512 : (int'(dt) + 1) * 128);
	endtask
	// third gap between level changes, the first two may straddle
	task automatic s_step(input logic [31:0] c, f, input logic [2:0] m,
		input int e);
		int n;
		wr(`LCDT_ADDR_FRAME, f);
		set_ctl(c);
		// sleep only once the clock source suits it
		sys_sleep_mode <= m;
		repeat (3)
			lvl_wait(n);
		chk(n == 5000 ? 0 : n, e);
	endtask
	task automatic s_blank();
		sys_sleep_mode <= 3'h0;
		wr(`LCDT_ADDR_FRAME, 32'h700);
		set_ctl(32'h705);
		wait_flag();
		wait_flag();
		chk({com_level, seg_level, com_oe, seg_oe}, {62'hf, 25'h1ffffff});
		rd(8'h40);
		chk(rdat, 32'h3c);
		set_ctl(32'h0);
		repeat (4) @(posedge aclk);
		chk(com_port_sel, 4'hf);
	endtask
	task automatic s_mask();
		wr(`LCDT_ADDR_MASK, 32'h1000000);
		set_ctl(32'h601);
		wait_flag();
		chk({com_port_sel, seg_port_sel}, {4'h8, 25'h1000000});
	endtask
	// main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, clr, vlcd_target_reached} = 4'h0;
		{timer_osc_pin, xtal_osc_clk, sys_sleep_mode} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		err_total = 0;
		comparisons = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({com_port_sel, seg_port_sel, com_oe}, 33'h1fffffff0);
		s_bus();
		wr(`LCDT_ADDR_FRAME, 32'h700);
		set_ctl(32'h701);
		repeat (300) @(posedge aclk);
		chk({com_oe, seg_oe}, 29'h0);
		vlcd_target_reached <= 1'b1;
		s_lit(8'ha5, 1'b0);
		s_lit(8'h5a, 1'b0);
		s_drive(3'h0);
		s_drive(3'h2);
		s_drive(3'h7);
		s_lit(8'h3c, 1'b1);
		s_step(32'h701, 32'h700, 3'h0, 16);
		s_step(32'h701, 32'h721, 3'h1, 192);
		s_step(32'h701, 32'h772, 3'h0, 1024);
		s_step(32'h701, 32'h713, 3'h3, 512);
		s_step(32'h701, 32'h734, 3'h0, 2048);
		s_step(32'h701, 32'h705, 3'h0, 1024);
		s_step(32'h701, 32'h706, 3'h0, 2048);
		s_step(32'h701, 32'h707, 3'h0, 4096);
		s_step(32'hf31, 32'h700, 3'h4, 0);
		s_step(32'hf31, 32'h700, 3'h2, 128);
		s_step(32'hf11, 32'h700, 3'h0, 256);
		s_blank();
		s_mask();
		tally_and_finish();
	end
endmodule
`default_nettype wire
